/* dram_ctrl_params.svh */
/*
 * shared constants for the two-port memory controller front end:
 * burst types, response codes, memory bus widths, lane rate and timing counts.
 * assumes inclusion by bare name from the port module.
 */
`ifndef DRAM_CTRL_PARAMS_SVH
`define DRAM_CTRL_PARAMS_SVH

`define BURST_FIXED 2'h0
`define BURST_INCR 2'h1
`define BURST_WRAP 2'h2
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
// memory data bus choices, in lines
`define DQ_WIDTH_NARROW 6'h10
`define DQ_WIDTH_WIDE 6'h20
// top lane rate for every supported memory type
`define MAX_RATE_MBPS 1066
// init timing may be retuned over the calibration bus, outside this port
`define INIT_TIME_NS 400
`define CLK_PERIOD_NS 20
`define INIT_CYCLES ((`INIT_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

/* dram_ctrl_pkg.sv */
/*
 * types used by the port engine; the memory model imports none.
 * assumes dram_ctrl_params.svh sits in the include path.
 */
package dram_ctrl_pkg;
    typedef enum logic [1:0]
    {
        ST_IDLE = 2'b00,
        ST_WRITE = 2'b01,
        ST_WRESP = 2'b10,
        ST_READ = 2'b11
    } port_state_t;
endpackage

/* dram_store.sv */
/*
 * word memory behind one port; byte-lane write, registered read data.
 * assumes a single clock shared with the port engine that drives it.
 */
`timescale 1ns/1ns
module dram_store #(
    parameter int DATA_W = 256,
    parameter int ADDR_W = 6
) (
    input wire logic clk,
    input wire logic wr_en,
    input wire logic [ADDR_W-1:0] wr_addr,
    input wire logic [DATA_W-1:0] wr_data,
    input wire logic [DATA_W/8-1:0] wr_strb,
    input wire logic [ADDR_W-1:0] rd_addr,
    output logic [DATA_W-1:0] rd_data
);
    logic [DATA_W-1:0] mem [0:(1<<ADDR_W)-1];

    // no reset on the array; read data registered for timing
    always_ff @(posedge clk)
    begin
        for (int i = 0; i < DATA_W / 8; i++)
        begin
            if (wr_en && wr_strb[i])
            begin
                mem[wr_addr][i*8 +: 8] <= wr_data[i*8 +: 8];
            end
        end
        rd_data <= mem[rd_addr];
    end
endmodule

/* dram_port.sv */
/*
 * one fabric target port of the memory controller: shared read/write
 * request channel, write data, write response and read data channels.
 * instantiate once at 256 bits and once at 128 bits, each on its own
 * port clock; assumes the master keeps the AXI-style handshake rules.
 */
`timescale 1ns/1ns
`include "dram_ctrl_params.svh"

// Functional notes
// - two independent ports exist, instantiated at 256 and 128 data bits.
// - device computes each beat address from burst type and beat size.
// - request transfers when request valid and request accept are both high.
// - device returns write response with tag; completes on response ready.
// - read beats carry tag, valid and last; transfer needs read ready.
// - every read beat carries a 2-bit response code.
// - data widths follow the port; each port runs on its own clock.
// - DDR3, DDR3L, LPDDR3, LPDDR2 supported up to 1066 Mbps per lane.
// - memory data bus width is 16 or 32 bits.
// - an I2C calibration bus reaches the configuration registers.
// - the PHY is reached only through the controller.
// - active-low reset clears the port; initialisation repeats afterwards.
module dram_port
    import dram_ctrl_pkg::*;
#(
    parameter int DATA_W = 256,
    parameter int ADDR_W = 6,
    parameter int INIT_CYC = `INIT_CYCLES
) (
    input wire logic aclk,
    input wire logic nrst,
    input wire logic init_sequencer_go,
    input wire logic init_sequencer_reset,
    output logic init_done,
    input wire logic request_valid,
    output logic request_accept,
    input wire logic request_is_write,
    input wire logic [31:0] request_address,
    input wire logic [1:0] request_burst_type,
    input wire logic [7:0] request_tag,
    input wire logic [7:0] request_beat_count,
    input wire logic [1:0] request_lock_type,
    input wire logic [2:0] request_beat_size,
    input wire logic write_valid,
    output logic write_ready,
    input wire logic [DATA_W-1:0] write_data,
    input wire logic [DATA_W/8-1:0] write_strobe,
    input wire logic [7:0] write_tag,
    input wire logic write_final_beat,
    output logic wresp_valid,
    input wire logic wresp_ready,
    output logic [7:0] wresp_tag,
    output logic [1:0] wresp_code,
    output logic read_valid,
    input wire logic read_ready,
    output logic [DATA_W-1:0] read_data,
    output logic [7:0] read_tag,
    output logic [1:0] read_resp,
    output logic read_final_beat
);
    localparam int LANE_BITS = $clog2(DATA_W / 8);

    typedef struct packed {
        port_state_t st;
        logic init_busy;
        logic init_done;
        logic [9:0] init_cnt;
        logic [31:0] addr;
        logic [7:0] len;
        logic [7:0] left;
        logic [1:0] burst;
        logic [2:0] size;
        logic [7:0] tag;
        logic [1:0] resp;
        logic rd_pend;
        logic rd_hold;
        logic last;
    } port_regs_t;

    port_regs_t q_r;
    port_regs_t q_nxt;
    logic [DATA_W-1:0] rd_word;
    logic mem_we;
    logic rd_fire;

    // next address of a burst from type and size; fixed keeps the address
    // wrap window is aligned to its span, so its base follows from any beat
    function automatic logic [31:0] next_addr(input logic [31:0] a, input logic [1:0] bt,
                                              input logic [2:0] sz, input logic [7:0] len);
        logic [31:0] step;
        logic [31:0] span;
        logic [31:0] lo;
        logic [31:0] n;
        step = 32'h1 << sz;
        span = step * ({24'h0, len} + 32'h1);
        lo = a & ~(span - 32'h1);
        n = a + step;
        if (bt == `BURST_FIXED)
            n = a;
        else if (bt == `BURST_WRAP && n >= lo + span)
            n = lo;
        return n;
    endfunction

    // word index of a byte address inside the local store
    function automatic logic [ADDR_W-1:0] word_of(input logic [31:0] a);
        return a[LANE_BITS +: ADDR_W];
    endfunction

    // take requests only when idle and initialised
    assign request_accept = (q_r.st == ST_IDLE) && q_r.init_done && !init_sequencer_reset;
    // accept write beats while a write burst is open
    assign write_ready = (q_r.st == ST_WRITE);
    assign wresp_valid = (q_r.st == ST_WRESP);
    assign wresp_tag = q_r.tag;
    assign wresp_code = `RESP_OKAY;
    assign read_valid = q_r.rd_hold;
    assign read_tag = q_r.tag;
    assign read_resp = q_r.resp;
    assign read_final_beat = q_r.last;
    assign read_data = rd_word;
    assign init_done = q_r.init_done;
    // each beat written once accepted; response only after last
    assign mem_we = write_valid && write_ready;
    assign rd_fire = read_valid && read_ready;

    // state update for init, request, write and read sequencing
    always_comb
    begin
        q_nxt = q_r;
        // start launches the init counter, sequencer reset holds idle
        if (init_sequencer_reset)
        begin
            q_nxt.init_busy = 1'b0;
            q_nxt.init_done = 1'b0;
            q_nxt.init_cnt = 10'h0;
        end
        else if (init_sequencer_go && !q_r.init_busy && !q_r.init_done)
        begin
            q_nxt.init_busy = 1'b1;
            q_nxt.init_cnt = 10'(INIT_CYC);
        end
        else if (q_r.init_busy)
        begin
            q_nxt.init_cnt = q_r.init_cnt - 10'h1;
            if (q_r.init_cnt == 10'h1)
            begin
                q_nxt.init_busy = 1'b0;
                q_nxt.init_done = 1'b1;
            end
        end
        q_nxt.rd_pend = 1'b0;
        case (q_r.st)
            ST_IDLE:
            begin
                if (request_valid && request_accept)
                begin
                    q_nxt.addr = request_address;
                    q_nxt.len = request_beat_count;
                    q_nxt.left = request_beat_count;
                    q_nxt.burst = request_burst_type;
                    q_nxt.size = request_beat_size;
                    q_nxt.tag = request_tag;
                    // type bit selects write or read path
                    if (request_is_write)
                        q_nxt.st = ST_WRITE;
                    else
                    begin
                        q_nxt.st = ST_READ;
                        q_nxt.rd_pend = 1'b1;
                        q_nxt.last = (request_beat_count == 8'h0);
                    end
                end
            end
            ST_WRITE:
            begin
                if (mem_we)
                begin
                    // step address by burst type and size
                    q_nxt.addr = next_addr(q_r.addr, q_r.burst, q_r.size, q_r.len);
                    if (q_r.left != 8'h0)
                        q_nxt.left = q_r.left - 8'h1;
                    // burst closes only on the marked final beat
                    if (write_final_beat)
                        q_nxt.st = ST_WRESP;
                end
            end
            ST_WRESP:
            begin
                // response holds until the master takes it
                if (wresp_ready)
                    q_nxt.st = ST_IDLE;
            end
            ST_READ:
            begin
                if (q_r.rd_pend)
                begin
                    q_nxt.rd_hold = 1'b1;
                    // oversize beats report a slave error
                    q_nxt.resp = (q_r.size > 3'(LANE_BITS)) ? `RESP_SLVERR : `RESP_OKAY;
                end
                else if (rd_fire)
                begin
                    q_nxt.rd_hold = 1'b0;
                    if (q_r.last)
                        q_nxt.st = ST_IDLE;
                    else
                    begin
                        q_nxt.addr = next_addr(q_r.addr, q_r.burst, q_r.size, q_r.len);
                        q_nxt.left = q_r.left - 8'h1;
                        q_nxt.last = (q_r.left == 8'h1);
                        q_nxt.rd_pend = 1'b1;
                    end
                end
            end
            default:
                q_nxt.st = ST_IDLE;
        endcase
    end

    // asynchronous low reset clears all port engine state, not the store array or its read register
    // every port register runs on the port clock
    always_ff @(posedge aclk or negedge nrst)
    begin
        if (!nrst)
            q_r <= '0;
        else
            q_r <= q_nxt;
    end

    // read data registered inside the store, one cycle after addressing
    // width follows DATA_W; the store is reached only via this engine
    dram_store #(
        .DATA_W(DATA_W),
        .ADDR_W(ADDR_W)
    ) u_store (
        .clk(aclk),
        .wr_en(mem_we),
        .wr_addr(word_of(q_r.addr)),
        .wr_data(write_data),
        .wr_strb(write_strobe),
        .rd_addr(word_of(q_r.addr)),
        .rd_data(rd_word)
    );

    a_req_accept_idle:
        assert property (@(posedge aclk) disable iff (!nrst)
            request_valid && request_accept |=> !request_accept)
        else $error("second request taken during a burst");
    a_wresp_after_last:
        assert property (@(posedge aclk) disable iff (!nrst)
            mem_we && write_final_beat |=> wresp_valid)
        else $error("no response after final write beat");
    a_wresp_hold:
        assert property (@(posedge aclk) disable iff (!nrst)
            wresp_valid && !wresp_ready |=> wresp_valid && $stable(wresp_tag))
        else $error("write response dropped before ready");
    a_read_hold:
        assert property (@(posedge aclk) disable iff (!nrst)
            read_valid && !read_ready |=> read_valid && $stable(read_final_beat))
        else $error("read beat dropped before ready");
    a_read_first_beat:
        assert property (@(posedge aclk) disable iff (!nrst)
            request_valid && request_accept && !request_is_write |=> ##1 read_valid)
        else $error("read beat not offered two cycles after request");
    a_fixed_addr:
        assert property (@(posedge aclk) disable iff (!nrst)
            mem_we && q_r.burst == `BURST_FIXED |=> $stable(q_r.addr))
        else $error("fixed burst address moved");
    a_read_resp_code:
        assert property (@(posedge aclk) disable iff (!nrst)
            read_valid && q_r.size <= 3'(LANE_BITS) |-> read_resp == `RESP_OKAY)
        else $error("bad response on legal beat");
    a_one_response:
        assert property (@(posedge aclk) disable iff (!nrst)
            wresp_valid && wresp_ready |=> !wresp_valid)
        else $error("second response for one burst");
    a_init_hold:
        assert property (@(posedge aclk) disable iff (!nrst)
            init_sequencer_reset |=> !init_done)
        else $error("init done while sequencer reset");
endmodule

/* fabric_master.sv */
/* fabric master model for one controller port: request, write and
   read channels. assumes a rising-edge port clock; drives on falling. */
`timescale 1ns/1ns
module fabric_master #(
    parameter int DW = 128
) (
    input wire logic aclk,
    output logic request_valid,
    input wire logic request_accept,
    output logic request_is_write,
    output logic [31:0] request_address,
    output logic [1:0] request_burst_type,
    output logic [7:0] request_tag,
    output logic [7:0] request_beat_count,
    output logic [1:0] request_lock_type,
    output logic [2:0] request_beat_size,
    output logic write_valid,
    input wire logic write_ready,
    output logic [DW-1:0] write_data,
    output logic [DW/8-1:0] write_strobe,
    output logic [7:0] write_tag,
    output logic write_final_beat,
    input wire logic wresp_valid,
    output logic wresp_ready,
    input wire logic [7:0] wresp_tag,
    input wire logic [1:0] wresp_code,
    input wire logic read_valid,
    output logic read_ready,
    input wire logic [DW-1:0] read_data,
    input wire logic [7:0] read_tag,
    input wire logic [1:0] read_resp,
    input wire logic read_final_beat
);
    // quiet bus at time zero
    initial
    begin
        {request_valid, write_valid, wresp_ready, read_ready, write_final_beat} = 5'h00;
        {request_is_write, request_address, request_burst_type, request_tag} = 43'h0;
        {request_beat_count, request_lock_type, request_beat_size} = 13'h0;
        {write_data, write_strobe, write_tag} = '0;
    end

    task automatic req(input logic w, input logic [31:0] a, input logic [1:0] bt,
        input logic [7:0] len, input logic [2:0] sz, input logic [7:0] tg);
        int n = 0;
        @(negedge aclk);
        {request_is_write, request_address, request_burst_type, request_tag} = {w, a, bt, tg};
        {request_beat_count, request_lock_type, request_beat_size} = {len, tg[1:0], sz};
        request_valid = 1'b1;
        do @(posedge aclk); while (request_accept !== 1'b1 && ++n < 99);
        @(negedge aclk);
        request_valid = 1'b0;
        // released field shows the inverse, not a stale copy
        request_address = ~a;
    endtask

    task automatic wr(input logic [7:0] tg, input logic [DW-1:0] d[$],
        input logic [DW/8-1:0] s[$], input int st, output logic [9:0] b);
        int n;
        foreach (d[i])
        begin
            @(negedge aclk);
            {write_valid, write_data, write_strobe, write_tag} = {1'b1, d[i], s[i], tg};
            write_final_beat = (i == d.size() - 1);
            n = 0;
            do @(posedge aclk); while (write_ready !== 1'b1 && ++n < 99);
        end
        @(negedge aclk);
        {write_valid, write_final_beat} = 2'h0;
        write_data = ~write_data;
        repeat (st) @(negedge aclk);
        wresp_ready = 1'b1;
        n = 0;
        do @(posedge aclk); while (wresp_valid !== 1'b1 && ++n < 99);
        b = {wresp_code, wresp_tag};
        @(negedge aclk);
        wresp_ready = 1'b0;
    endtask

    // one beat per ready, stalled by st
    task automatic rd(input int beats, input int st, output logic [DW+10:0] q[$]);
        int n;
        q = {};
        repeat (beats)
        begin
            repeat (st) @(negedge aclk);
            @(negedge aclk);
            read_ready = 1'b1;
            n = 0;
            do @(posedge aclk); while (read_valid !== 1'b1 && ++n < 99);
            q.push_back({read_final_beat, read_resp, read_tag, read_data});
            @(negedge aclk);
            read_ready = 1'b0;
        end
    endtask
endmodule

/* dram_ctrl_axi_host_ports_tb.sv */
/* bench for one 128-bit controller port: reference byte image, fabric
   master model, reset and init. assumes fabric_master.sv is compiled. */
`timescale 1ns/1ns
module dram_ctrl_axi_host_ports_tb;
    localparam int DW = 128;
    localparam int ICYC = 2;
    logic core_clk, nrst, init_sequencer_go, init_sequencer_reset, init_done;
    logic request_valid, request_accept, request_is_write, write_valid, write_ready;
    logic write_final_beat, wresp_valid, wresp_ready, read_valid, read_ready;
    logic read_final_beat;
    logic [31:0] request_address, lfsr_r;
    logic [1:0] request_burst_type, request_lock_type, wresp_code, read_resp;
    logic [7:0] request_tag, request_beat_count, write_tag, wresp_tag, read_tag;
    logic [2:0] request_beat_size;
    logic [DW-1:0] write_data, read_data;
    logic [DW/8-1:0] write_strobe;
    // reference byte image of the 64-word store
    logic [7:0] mem [0:1023];
    int err_total, total_checks, nresp, st, a, bt, len;

    dram_port #(.DATA_W(DW), .INIT_CYC(ICYC)) DUT (.aclk(core_clk), .*);
    fabric_master #(.DW(DW)) MST (.aclk(core_clk), .*);

    initial
    begin
        core_clk = 1'b0;
        forever #10 core_clk = ~core_clk; // port clock only, no PHY clock
    end

    // completed responses, so a doubled answer shows up
    always @(posedge core_clk)
        if (wresp_valid && wresp_ready)
            nresp++;

    function automatic logic [31:0] rnd();
        lfsr_r = {lfsr_r[30:0], ^(lfsr_r & 32'h80200003)};
        return lfsr_r;
    endfunction

    // beat address: fixed, incrementing or wrapping at bytes*(len+1)
    function automatic int bad(int a, int bt, int sz, int len, int i);
        int nb = 1 << sz;
        int bnd = nb * (len + 1);
        if (bt == 0)
            return a;
        if (bt == 1)
            return a + i * nb;
        return (a / bnd) * bnd + (a % bnd + i * nb) % bnd;
    endfunction

    task automatic chk(input string nm, input logic [255:0] e, input logic [255:0] g);
        total_checks++;
        if (g !== e || $isunknown(g))
        begin
            err_total++;
            $display("MISMATCH %s exp %h got %h", nm, e, g);
        end
    endtask

    task automatic complete_run();
        $display("checks %0d errors %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    task automatic init_up();
        int n = 0;
        chk("accept_before_init", 0, request_accept);
        @(negedge core_clk);
        init_sequencer_go = 1'b1;
        do begin @(posedge core_clk); #1; n++; end while (init_done !== 1'b1 && n < 50);
        chk("init_edges", ICYC + 1, n);
        @(negedge core_clk);
        init_sequencer_go = 1'b0;
    endtask

    task automatic wburst(input logic [7:0] tg, input int a, bt, len, input logic part);
        logic [DW-1:0] d[$];
        logic [DW/8-1:0] s[$];
        logic [9:0] b;
        int w, n0;
        for (int i = 0; i <= len; i++)
        begin
            d.push_back({rnd(), rnd(), rnd(), rnd()});
            s.push_back(part ? (DW/8)'(rnd()) : '1);
            w = bad(a, bt, 4, len, i) & ~15;
            for (int k = 0; k < DW/8; k++)
                if (s[i][k])
                    mem[w + k] = d[i][8*k +: 8];
        end
        n0 = nresp;
        MST.req(1'b1, 32'(a), 2'(bt), 8'(len), 3'h4, tg);
        MST.wr(tg, d, s, st, b);
        repeat (3) @(posedge core_clk);
        chk("wresp", {2'h0, tg}, b);
        chk("wresp_count", 1, nresp - n0);
    endtask

    task automatic rburst(input logic [7:0] tg, input int a, bt, len, input logic [2:0] sz);
        logic [DW+10:0] q[$];
        logic [DW-1:0] e;
        int w;
        MST.req(1'b0, 32'(a), 2'(bt), 8'(len), sz, tg);
        MST.rd(len + 1, st, q);
        for (int i = 0; i <= len; i++)
        begin
            w = bad(a, bt, sz, len, i) & ~15;
            for (int k = 0; k < DW/8; k++)
                e[8*k +: 8] = mem[w + k];
            chk("read_meta", {i == len, sz > 3'h4 ? 2'h2 : 2'h0, tg}, q[i][DW+10:DW]);
            if (sz <= 3'h4)
                chk("read_data", e, q[i][DW-1:0]);
        end
    endtask

    initial
    begin
        {nrst, init_sequencer_go, init_sequencer_reset} = 3'h0;
        lfsr_r = 32'hb431;
        repeat (8) @(negedge core_clk);
        // the bench plays the user reset of the surrounding logic
        nrst = 1'b1;
        init_up();
        // fill every word first, so no byte of either image stays unknown
        wburst(8'h01, 0, 1, 63, 1'b0);
        // every burst type, prompt then slower master
        for (int t = 0; t < 3; t++)
        begin
            st = 2 * t;
            a = (t == 2) ? 32'h120 : 32'h40 * (t + 1);
            wburst(8'(8'h10 + t), a, t, 3, 1'b0);
            rburst(8'(8'h20 + t), a, t, 3, 3'h4);
        end
        // partial lanes over old data, then narrow and oversized beats
        wburst(8'h31, 32'h80, 1, 1, 1'b1);
        rburst(8'h32, 32'h88, 1, 1, 3'h3);
        rburst(8'h33, 32'h80, 1, 1, 3'h5);
        // random bursts against the reference image
        repeat (6)
        begin
            a = rnd() & 32'h1f0;
            bt = rnd() % 3;
            len = (2 << (rnd() % 3)) - 1;
            st = rnd() % 3;
            wburst(8'(rnd()), a, bt, len, 1'(rnd()));
            rburst(8'(rnd()), a, bt, len, 3'h4);
        end
        // sequencer reset holds the port closed
        @(negedge core_clk);
        init_sequencer_reset = 1'b1;
        @(posedge core_clk);
        #1;
        chk("seq_reset_accept", 0, request_accept);
        chk("seq_reset_done", 0, init_done);
        @(negedge core_clk);
        init_sequencer_reset = 1'b0;
        init_up();
        // master reset just after a write request is taken
        MST.req(1'b1, 32'h40, 2'h1, 8'h3, 3'h4, 8'h44);
        nrst = 1'b0;
        #1;
        chk("reset_outputs", 0, {init_done, write_ready, wresp_valid, read_valid});
        repeat (2) @(negedge core_clk);
        nrst = 1'b1;
        init_up();
        wburst(8'h45, 32'h40, 1, 0, 1'b0);
        rburst(8'h46, 32'h40, 1, 0, 3'h4);
        complete_run();
    end

    // hang guard, well beyond the expected run
    initial
    begin
        #200000;
        err_total++;
        $display("MISMATCH watchdog exp finish got hang");
        complete_run();
    end
endmodule
